// File: logic/int_prio_pkg.sv
// Constants and types for the interrupt source prioritizer
package int_prio_pkg;
  localparam int NUM_SRC = 22;
  localparam int SRC_W = 5;
  localparam int VEC_W = 16;
  // Non-maskable watchdog vector
  localparam logic [VEC_W-1:0] NMI_VECTOR = 16'h0004;
  // First maskable vector; level n sits at FIRST + 2*(n-1)
  localparam logic [VEC_W-1:0] FIRST_VECTOR = 16'h0006;
  // Highest maskable level (watchdog in interval mode) uses 16'h0004, the same value as NMI_VECTOR
  localparam logic [VEC_W-1:0] WDT_MASK_VECTOR = 16'h0004;
  // Source index positions (index equals priority level)
  localparam int SRC_WDT = 0;
  localparam int SRC_PIN_A = 1;
  localparam int SRC_PIN_D = 4;
  localparam int SRC_REMOTE_EDGE = 5;
  localparam int SRC_SERIAL_A = 6;
  localparam int SRC_SYNC_B = 7;
  localparam int SRC_ASYNC_TX = 8;
  localparam int SRC_WATCH_INT = 9;
  localparam int SRC_TIMER_A = 10;
  localparam int SRC_TIMER_B = 11;
  localparam int SRC_TIMER_C = 12;
  localparam int SRC_TIMER_D = 13;
  localparam int SRC_CONV = 14;
  localparam int SRC_WATCH_OVF = 15;
  localparam int SRC_KEY_A = 16;
  localparam int SRC_REM_ERR = 17;
  localparam int SRC_REM_GUIDE = 18;
  localparam int SRC_REM_DONE = 19;
  localparam int SRC_REM_FULL = 20;
  localparam int SRC_KEY_B = 21;
  localparam int NUM_PINS = 4;
  localparam int NUM_KEYS = 2;
  // Reset values
  localparam logic [NUM_SRC-1:0] FLAG_RESET = 22'h000000;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 22'h3fffff;
  // Edge mode encoding per pin: 00 falling, 01 rising, 1x both
  typedef logic [1:0] edge_mode_t;
  // Software flag access
  typedef struct packed {
    logic [NUM_SRC-1:0] set;
    logic [NUM_SRC-1:0] clr;
  } flag_cmd_t;
  // Acknowledge answer
  typedef struct packed {
    logic nmi;
    logic [SRC_W-1:0] level;
    logic [VEC_W-1:0] vector;
  } ack_info_t;
endpackage

// File: logic/interrupt_source_prioritizer.sv
// Interrupt source collection, fixed priority arbitration and vectoring
`timescale 1ns/1ps
module interrupt_source_prioritizer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wdt_overflow,
  input wire logic i_wdt_interval_mode,
  input wire logic [int_prio_pkg::NUM_PINS-1:0] i_ext_pin,
  input wire logic [int_prio_pkg::NUM_KEYS-1:0] i_key_pin,
  input wire int_prio_pkg::edge_mode_t [3:0] i_ext_edge_mode_a,
  input wire logic [1:0] i_ext_edge_mode_b,
  input wire logic [1:0] i_key_mode_a,
  input wire logic [1:0] i_key_mode_b,
  input wire logic i_remote_edge_req,
  input wire logic i_async_rx_done_req,
  input wire logic i_sync_ch_a_done_req,
  input wire logic i_sync_ch_b_done_req,
  input wire logic i_async_tx_done_req,
  input wire logic i_watch_interval_req,
  input wire logic i_watch_overflow_req,
  input wire logic i_timer_a_match_req,
  input wire logic i_timer_b_match_req,
  input wire logic i_timer_c_match_req,
  input wire logic i_timer_cascade_mode,
  input wire logic i_timer_cascade_match,
  input wire logic i_timer_d_match_req,
  input wire logic i_conversion_done_req,
  input wire logic i_remote_error_req,
  input wire logic i_remote_guide_req,
  input wire logic i_remote_rx_done_req,
  input wire logic i_remote_shift_full_req,
  input wire int_prio_pkg::flag_cmd_t i_flag_cmd,
  input wire int_prio_pkg::flag_cmd_t i_mask_cmd,
  input wire logic i_global_enable_flag,
  input wire logic i_ack,
  output logic o_irq,
  output logic o_nmi,
  output logic o_standby_release,
  output int_prio_pkg::ack_info_t o_pending,
  output logic o_ack_valid,
  output int_prio_pkg::ack_info_t o_ack_info,
  output logic [int_prio_pkg::NUM_SRC-1:0] o_request_flag,
  output logic [int_prio_pkg::NUM_SRC-1:0] o_mask_flag
);
  import int_prio_pkg::*;

  // Pin synchronisers; first stage read only by second stage
  logic [NUM_PINS+NUM_KEYS-1:0] pin_s1_reg, pin_s1_next;
  logic [NUM_PINS+NUM_KEYS-1:0] pin_s2_reg, pin_s2_next;
  logic [NUM_PINS+NUM_KEYS-1:0] pin_s3_reg, pin_s3_next;
  logic [NUM_PINS+NUM_KEYS-1:0] pin_edge;
  logic [NUM_SRC-1:0] flag_reg, flag_next;
  logic [NUM_SRC-1:0] mask_reg, mask_next;
  logic nmi_reg, nmi_next;
  logic [NUM_SRC-1:0] src_event;
  logic [NUM_SRC-1:0] eligible;
  logic any_eligible;
  logic [SRC_W-1:0] win_level;
  logic [NUM_SRC-1:0] ack_clr;
  logic irq_reg, irq_next;
  logic sb_reg, sb_next;
  ack_info_t pend_reg, pend_next;
  logic ack_valid_reg, ack_valid_next;
  ack_info_t ack_info_reg, ack_info_next;

  // Synchroniser shift
  always_comb begin
    pin_s1_next = {i_key_pin, i_ext_pin};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
  end

  // Edge detection per pin; modes select falling, rising or both
  genvar g;
  generate
    for (g = 0; g < NUM_PINS + NUM_KEYS; g++) begin : g_edge
      logic [1:0] mode;
      logic rise;
      logic fall;
      if (g < NUM_PINS) begin : g_ext
        // Pin A mode lives in mode_b, others in mode_a fields
        if (g == 0) begin : g_a
          assign mode = i_ext_edge_mode_b;
        end else begin : g_bcd
          assign mode = i_ext_edge_mode_a[g];
        end
      end else if (g == NUM_PINS) begin : g_ka
        assign mode = i_key_mode_a;
      end else begin : g_kb
        assign mode = i_key_mode_b;
      end
      assign rise = pin_s2_reg[g] & ~pin_s3_reg[g];
      assign fall = ~pin_s2_reg[g] & pin_s3_reg[g];
      // Key groups detect a falling key return by default
      assign pin_edge[g] = mode[1] ? (rise | fall) :
                           (mode[0] ? rise : fall);
    end
  endgenerate

  // Source events, index equals priority level
  always_comb begin
    src_event = '0;
    src_event[SRC_WDT] = i_wdt_overflow & i_wdt_interval_mode;
    src_event[SRC_PIN_D:SRC_PIN_A] = pin_edge[NUM_PINS-1:0];
    src_event[SRC_REMOTE_EDGE] = i_remote_edge_req;
    src_event[SRC_SERIAL_A] = i_async_rx_done_req |
                              i_sync_ch_a_done_req;
    src_event[SRC_SYNC_B] = i_sync_ch_b_done_req;
    src_event[SRC_ASYNC_TX] = i_async_tx_done_req;
    src_event[SRC_WATCH_INT] = i_watch_interval_req;
    src_event[SRC_TIMER_A] = i_timer_a_match_req;
    src_event[SRC_TIMER_B] = i_timer_b_match_req;
    // Cascade mode uses the combined 16-bit match instead
    src_event[SRC_TIMER_C] = i_timer_cascade_mode ?
      i_timer_cascade_match : i_timer_c_match_req;
    src_event[SRC_TIMER_D] = i_timer_d_match_req;
    src_event[SRC_CONV] = i_conversion_done_req;
    src_event[SRC_WATCH_OVF] = i_watch_overflow_req;
    src_event[SRC_KEY_A] = pin_edge[NUM_PINS];
    src_event[SRC_REM_ERR] = i_remote_error_req;
    src_event[SRC_REM_GUIDE] = i_remote_guide_req;
    src_event[SRC_REM_DONE] = i_remote_rx_done_req;
    src_event[SRC_REM_FULL] = i_remote_shift_full_req;
    src_event[SRC_KEY_B] = pin_edge[NUM_PINS+1];
  end

  // Fixed priority: lowest index among unmasked, enabled pending flags
  always_comb begin
    eligible = flag_reg & ~mask_reg &
               {NUM_SRC{i_global_enable_flag}};
    any_eligible = |eligible;
    win_level = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win_level = SRC_W'(i);
      end
    end
  end

  // Acknowledge clear; only a maskable winner loses its flag here
  always_comb begin
    ack_clr = '0;
    if (i_ack && !nmi_reg && any_eligible) begin
      ack_clr[win_level] = 1'b1;
    end
  end

  // Request flags: an event set beats any clear in the same cycle,
  // so a request that lands during its own acknowledge is not lost
  always_comb begin
    flag_next = ((flag_reg | i_flag_cmd.set) & ~i_flag_cmd.clr & ~ack_clr)
                | src_event;
    if (i_rst) begin
      flag_next = FLAG_RESET;
    end
  end

  // Request flag register
  always_ff @(posedge i_clk) begin
    flag_reg <= flag_next;
  end

  // Mask flags: a clear beats a set in the same cycle
  always_comb begin
    mask_next = (mask_reg | i_mask_cmd.set) & ~i_mask_cmd.clr;
    if (i_rst) begin
      mask_next = MASK_RESET;
    end
  end

  // Mask flag register
  always_ff @(posedge i_clk) begin
    mask_reg <= mask_next;
  end

  // Watchdog mode overflow goes only to the non-maskable latch; a new
  // overflow in the acknowledge cycle keeps the latch set
  always_comb begin
    nmi_next = nmi_reg;
    if (i_ack && nmi_reg) begin
      nmi_next = 1'b0;
    end
    if (i_wdt_overflow && !i_wdt_interval_mode) begin
      nmi_next = 1'b1;
    end
    if (i_rst) begin
      nmi_next = 1'b0;
    end
  end

  // Non-maskable latch
  always_ff @(posedge i_clk) begin
    nmi_reg <= nmi_next;
  end

  // Request lines follow next-state flags so they match the flag outputs
  always_comb begin
    irq_next = nmi_next | (|(flag_next & ~mask_next &
               {NUM_SRC{i_global_enable_flag}}));
    // Standby release ignores the global enable, not the masks
    sb_next = nmi_next | (|(flag_next & ~mask_next));
    if (i_rst) begin
      irq_next = 1'b0;
      sb_next = 1'b0;
    end
  end

  // Request line registers
  always_ff @(posedge i_clk) begin
    irq_reg <= irq_next;
    sb_reg <= sb_next;
  end

  // Pending winner; the non-maskable request overrides any level
  always_comb begin
    pend_next.nmi = nmi_reg;
    pend_next.level = win_level;
    pend_next.vector = FIRST_VECTOR +
      VEC_W'({win_level, 1'b0}) - VEC_W'(2);
    if (win_level == SRC_W'(SRC_WDT)) begin
      pend_next.vector = WDT_MASK_VECTOR;
    end
    if (nmi_reg) begin
      pend_next.level = '0;
      pend_next.vector = NMI_VECTOR;
    end
    if (i_rst) begin
      pend_next = '0;
    end
  end

  // Pending winner register
  always_ff @(posedge i_clk) begin
    pend_reg <= pend_next;
  end

  // Acknowledge answer; a refused acknowledge leaves the last answer
  always_comb begin
    ack_valid_next = i_ack & (nmi_reg | any_eligible);
    ack_info_next = ack_info_reg;
    if (i_ack && (nmi_reg || any_eligible)) begin
      ack_info_next = pend_next;
    end
    if (i_rst) begin
      ack_valid_next = 1'b0;
      ack_info_next = '0;
    end
  end

  // Acknowledge answer registers
  always_ff @(posedge i_clk) begin
    ack_valid_reg <= ack_valid_next;
    ack_info_reg <= ack_info_next;
  end

  // Pin synchroniser registers; no reset, the pins settle within three
  // clocks and reset is held longer than that
  always_ff @(posedge i_clk) begin
    pin_s1_reg <= pin_s1_next;
    pin_s2_reg <= pin_s2_next;
    pin_s3_reg <= pin_s3_next;
  end

  // Every output comes straight from a register
  assign o_irq = irq_reg;
  assign o_nmi = nmi_reg;
  assign o_standby_release = sb_reg;
  assign o_pending = pend_reg;
  assign o_ack_valid = ack_valid_reg;
  assign o_ack_info = ack_info_reg;
  assign o_request_flag = flag_reg;
  assign o_mask_flag = mask_reg;
endmodule

// File: test/isp_chk.sv
// Port-level assertions for the interrupt source prioritizer
`timescale 1ns/1ps
module isp_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wdt_overflow,
  input wire logic i_wdt_interval_mode,
  input wire logic i_global_enable_flag,
  input wire logic i_timer_a_match_req,
  input wire int_prio_pkg::flag_cmd_t i_mask_cmd,
  input wire logic i_ack,
  input wire logic o_irq,
  input wire logic o_nmi,
  input wire logic o_standby_release,
  input wire int_prio_pkg::ack_info_t o_pending,
  input wire logic o_ack_valid,
  input wire int_prio_pkg::ack_info_t o_ack_info,
  input wire logic [int_prio_pkg::NUM_SRC-1:0] o_request_flag,
  input wire logic [int_prio_pkg::NUM_SRC-1:0] o_mask_flag
);
  import int_prio_pkg::*;
  // One clock domain, so clock and reset are stated once
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_reset_state: assert property ($past(i_rst) |->
    o_mask_flag == 22'h3fffff && o_request_flag == 22'h0) else $error("reset");
  a_wdt_nmi: assert property (i_wdt_overflow && !i_ack &&
    !i_wdt_interval_mode |=> o_nmi) else $error("nmi not raised");
  a_wdt_one_path: assert property (i_wdt_overflow &&
    !i_wdt_interval_mode && !o_request_flag[0] |=> !o_request_flag[0])
    else $error("watchdog took both paths");
  a_wdt_masked: assert property (i_wdt_overflow &&
    i_wdt_interval_mode && !o_nmi |=> o_request_flag[0] && !o_nmi)
    else $error("interval overflow wrong path");
  a_timer_flag: assert property (i_timer_a_match_req |=>
    o_request_flag[10]) else $error("timer flag not set");
  a_irq_cause: assert property (o_irq |-> o_nmi ||
    |(o_request_flag & ~o_mask_flag)) else $error("irq without cause");
  a_ack_vector: assert property (o_ack_valid && !o_ack_info.nmi |->
    o_ack_info.vector == 16'h0004 + {10'h0, o_ack_info.level, 1'b0})
    else $error("ack vector wrong");
  a_ack_nmi_first: assert property (i_ack && o_nmi |=>
    o_ack_valid && o_ack_info.nmi && o_ack_info.vector == 16'h0004)
    else $error("nmi not served first");
  a_mask_clear: assert property (|i_mask_cmd.clr |=>
    (o_mask_flag & $past(i_mask_cmd.clr)) == 22'h0) else $error("mask");
  a_standby_cause: assert property (o_standby_release ==
    (o_nmi || |(o_request_flag & ~o_mask_flag))) else $error("standby");
  a_irq_enable: assert property (o_irq && !o_nmi |->
    $past(i_global_enable_flag)) else $error("irq while disabled");
  a_pend_nmi: assert property (o_pending.nmi == $past(o_nmi))
    else $error("pending nmi late");
  a_pend_vector: assert property (!$past(i_rst) |->
    o_pending.vector == 16'h0004 + {10'h0, o_pending.level, 1'b0})
    else $error("pending vector wrong");
  // Main scenarios seen at least once
  cover property (o_ack_valid && o_ack_info.nmi);
  cover property (o_ack_valid && o_ack_info.level == 5'h15);
  cover property (o_irq && !o_nmi);
endmodule
bind interrupt_source_prioritizer isp_chk isp_chk_i (.*);

// File: test/core_model.sv
// Core stand-in that acknowledges presented requests
`timescale 1ns/1ps
module core_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_slow,
  input wire logic i_irq,
  output logic o_ack = 1'b0
);
  logic [1:0] gap_reg = 2'h0;
  // Slow mode leaves a three-cycle gap after each acknowledge
  always @(negedge i_clk) begin
    o_ack <= i_en && i_irq && (!i_slow || gap_reg == 2'h0);
    if (i_en && i_irq && gap_reg == 2'h0) gap_reg <= 2'h3;
    else if (gap_reg != 2'h0) gap_reg <= gap_reg - 2'h1;
  end
endmodule

// File: test/tb_interrupt_source_prioritizer.sv
// Self-checking testbench for the interrupt source prioritizer
`timescale 1ns/1ps
module tb_interrupt_source_prioritizer;
  import int_prio_pkg::*;
  // Flag bit of each pin and key group, in pin vector order
  localparam logic [21:0] lv [6] = '{22'h2, 22'h4, 22'h8, 22'h10,
    22'h10000, 22'h200000};
  logic i_clk = 0, i_rst = 1, wm = 1, cas = 0, ge = 0, ack, irq, nmi, av;
  logic core_en = 0, slow = 0, sb;
  logic [21:0] ev = '0, exp_f = '0, fl, mk, x;
  logic [5:0] pin = '0;
  logic [4:0] lvl;
  logic [1:0] md [6] = '{default: 2'h0};
  flag_cmd_t fc = '0, mc = '0;
  ack_info_t ai;
  bit expn = 0;
  int errors = 0, checked = 0, cyc = 0, p;
  interrupt_source_prioritizer interrupt_source_prioritizer_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_wdt_overflow(ev[0]),
    .i_wdt_interval_mode(wm), .i_ext_pin(pin[3:0]), .i_key_pin(pin[5:4]),
    .i_ext_edge_mode_a({md[3], md[2], md[1], 2'h0}),
    .i_ext_edge_mode_b(md[0]), .i_key_mode_a(md[4]), .i_key_mode_b(md[5]),
    .i_remote_edge_req(ev[5]), .i_async_rx_done_req(ev[6]),
    .i_sync_ch_a_done_req(ev[21]), .i_sync_ch_b_done_req(ev[7]),
    .i_async_tx_done_req(ev[8]), .i_watch_interval_req(ev[9]),
    .i_watch_overflow_req(ev[15]), .i_timer_a_match_req(ev[10]),
    .i_timer_b_match_req(ev[11]), .i_timer_c_match_req(ev[12]),
    .i_timer_cascade_mode(cas), .i_timer_cascade_match(ev[1]),
    .i_timer_d_match_req(ev[13]), .i_conversion_done_req(ev[14]),
    .i_remote_error_req(ev[17]), .i_remote_guide_req(ev[18]),
    .i_remote_rx_done_req(ev[19]), .i_remote_shift_full_req(ev[20]),
    .i_flag_cmd(fc), .i_mask_cmd(mc), .i_global_enable_flag(ge),
    .i_ack(ack), .o_irq(irq), .o_nmi(nmi), .o_standby_release(sb),
    .o_pending(), .o_ack_valid(av), .o_ack_info(ai),
    .o_request_flag(fl), .o_mask_flag(mk));
  core_model core_model_i (.i_clk(i_clk), .i_en(core_en), .i_slow(slow),
    .i_irq(irq), .o_ack(ack));
  always #4 i_clk = ~i_clk;
  task automatic chk(logic [21:0] g, e);
    checked++;
    if (g !== e) errors++;
    if (g !== e) $display("ERROR %0t: got %h want %h", $time, g, e);
  endtask
  task automatic clr();
    fc.clr = '1;
    @(negedge i_clk) fc.clr = '0;
  endtask
  // Pulse events for one cycle, then look at the flags they left
  task automatic fire(logic [21:0] e, x);
    @(negedge i_clk) ev = e;
    @(negedge i_clk) ev = '0;
    chk(fl, x);
    clr();
  endtask
  // Core drains until every expected acknowledge was seen, bounded
  task automatic drain();
    core_en = 1;
    for (int t = 0; t < 300 && (exp_f != 0 || expn); t++) @(negedge i_clk);
    core_en = 0;
  endtask
  task automatic end_of_test();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Acknowledges name the NMI first, then the lowest expected level
  always @(negedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      end_of_test();
    end
    if (av === 1'b1 && expn) begin
      chk(ai, {1'b1, 5'h0, 16'h0004});
      expn = 0;
    end else if (av === 1'b1) begin
      for (int n = 21; n >= 0; n--) if (exp_f[n]) lvl = 5'(n);
      chk(ai, {1'b0, lvl, 16'h0004 + {10'h0, lvl, 1'b0}});
      exp_f &= exp_f - 22'h1;
    end
  end
  initial begin
    void'($urandom(32'h95ec));
    repeat (4) @(negedge i_clk);
    i_rst = 0;
    chk(mk, 22'h3fffff);
    chk(fl, 22'h0);
    // A masked flag must not reach the core even when enabled
    ge = 1;
    fc.set = 22'h8;
    @(negedge i_clk) fc.set = '0;
    repeat (2) @(negedge i_clk);
    chk({21'h0, irq}, 22'h0);
    chk({21'h0, sb}, 22'h0);
    ge = 0;
    clr();
    $display("mask test done");
    for (int n = 0; n < 21; n++)
      if (n == 0 || n > 4 && n != 16)
        fire(22'h1 << n, 22'h1 << n);
    fire(22'h1 << 21, 22'h40);
    cas = 1;
    fire(22'h1000, 22'h0);
    fire(22'h2, 22'h1000);
    cas = 0;
    wm = 0;
    fire(22'h1, 22'h0);
    chk({21'h0, nmi}, 22'h1);
    $display("event test done");
    // Random edge modes; only an edge of the chosen kind sets a flag
    for (int k = 0; k < 24; k++) begin
      p = $urandom_range(5);
      md[p] = 2'($urandom);
      @(negedge i_clk) pin[p] = ~pin[p];
      repeat (5) @(negedge i_clk);
      x = md[p][1] || md[p][0] == pin[p] ? lv[p] : 22'h0;
      chk(fl, x);
      clr();
    end
    $display("pin test done");
    mc.clr = '1;
    @(negedge i_clk) mc.clr = '0;
    chk(mk, 22'h0);
    // The NMI is taken with global enable off
    expn = 1;
    drain();
    for (int k = 0; k < 8; k++) begin
      fc.set = k == 0 ? 22'h3fffff : 22'($urandom);
      exp_f = fc.set;
      @(negedge i_clk) fc.set = '0;
      chk(fl, exp_f);
      chk({21'h0, sb}, {21'h0, exp_f != 22'h0});
      ge = 1;
      slow = k[0];
      drain();
      ge = 0;
    end
    chk(fl, 22'h0);
    $display("priority test done");
    end_of_test();
  end
endmodule
